//--- hw/status_report_aggregator.sv
`timescale 1ns/1ns
`default_nettype none
module status_report_aggregator
  import status_report_pkg::*;
#(
  parameter int EXT_W = 16
) (
  input wire logic mclk,
  input wire logic rst_n,
  input wire std_events_s std_ev,
  input wire cmd_s cmd,
  input wire logic [EXT_W-1:0] ext_event,
  input wire logic [EXT_W-1:0] ext_enable,
  input wire logic error_queue_nonempty,
  input wire logic output_queue_nonempty,
  output logic flush_output_queue,
  output logic service_request,
  output logic [7:0] reply_data_q,
  output logic reply_valid_q,
  output logic [7:0] service_enable_q,
  output logic [7:0] event_enable_q,
  output logic [7:0] status_summary_byte,
  output logic [7:0] standard_event_flags_q
);
  // the extended summary is an or-reduce of the masked events, so any width from one up serves
  if (EXT_W < 1) begin : g_ext_w_check
    $error("EXT_W must be at least 1");
  end

  // command strobes taken apart, so the logic below reads plainly
  logic do_stb_query;
  logic do_serial_poll;
  logic do_esr_query;
  logic do_clear_status;
  logic at_terminator;
  logic do_sre_write;
  logic do_ese_write;
  logic [7:0] write_byte;

  // event pulses taken apart
  logic ev_operation_complete;
  logic ev_query_error;
  logic ev_device_error;
  logic ev_execution_error;
  logic ev_syntax_error;
  logic ev_power_on;

  // event register helpers
  logic [7:0] std_set;
  logic event_clear;
  logic [7:0] event_masked;

  // status byte helpers
  logic ext_summary;
  logic std_event_summary;
  logic error_available;
  logic message_available;
  logic [7:0] sb_low;
  logic [7:0] sb_enabled;
  logic master_summary_bit;

  // request flag helpers
  logic msb_q;
  logic msb_rise;
  logic flag_clear;
  logic request_service_flag_q;

  // reply helpers
  logic any_query;
  logic [7:0] poll_byte;
  logic [7:0] reply_d;

  // command fields; only one strobe per cycle is expected
  assign do_stb_query = cmd.stb_query;
  assign do_serial_poll = cmd.serial_poll;
  assign do_esr_query = cmd.esr_query;
  assign do_clear_status = cmd.clear_status;
  assign at_terminator = cmd.after_terminator;
  assign do_sre_write = cmd.sre_write;
  assign do_ese_write = cmd.ese_write;
  assign write_byte = cmd.wdata;

  // event pulses, each high for one cycle
  assign ev_operation_complete = std_ev.operation_complete;
  assign ev_query_error = std_ev.query_error;
  assign ev_device_error = std_ev.device_specific_error;
  assign ev_execution_error = std_ev.execution_error;
  assign ev_syntax_error = std_ev.command_syntax_error;
  assign ev_power_on = std_ev.power_on_event;

  // gather event pulses into their bit slots; bits 1 and 6 never set
  always_comb begin
    std_set = '0;
    std_set[SE_OPC] = ev_operation_complete;
    std_set[SE_QYE] = ev_query_error;
    std_set[SE_DDE] = ev_device_error;
    std_set[SE_EXE] = ev_execution_error;
    std_set[SE_CME] = ev_syntax_error;
    std_set[SE_PON] = ev_power_on;
  end

  // a read and a clear-status empty the register alike
  assign event_clear = do_esr_query | do_clear_status;

  // clear on read or clear-status; a new event in the same cycle survives,
  // since losing it would hide an error that the controller never saw
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      standard_event_flags_q <= EVENT_RESET;
    end else if (event_clear) begin
      standard_event_flags_q <= std_set;
    end else begin
      standard_event_flags_q <= standard_event_flags_q | std_set;
    end
  end

  // service request mask, full byte so any 0..255 value fits and reads back
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      service_enable_q <= MASK_RESET;
    end else if (do_sre_write) begin
      service_enable_q <= write_byte;
    end
  end

  // standard event mask, same width and reset as the service mask
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      event_enable_q <= MASK_RESET;
    end else if (do_ese_write) begin
      event_enable_q <= write_byte;
    end
  end

  // summaries of the masked registers and the queue levels
  assign ext_summary = |(ext_event & ext_enable);
  assign event_masked = standard_event_flags_q & event_enable_q;
  assign std_event_summary = |event_masked;
  assign error_available = error_queue_nonempty;
  assign message_available = output_queue_nonempty;

  // summary byte without bit 6; unused bits stay zero
  always_comb begin
    sb_low = '0;
    sb_low[SB_EXT] = ext_summary;
    sb_low[SB_ERR] = error_available;
    sb_low[SB_MSG] = message_available;
    sb_low[SB_STD] = std_event_summary;
  end

  // bit 6 of sb_low is always zero, so it never feeds itself
  assign sb_enabled = sb_low & service_enable_q;
  assign master_summary_bit = |sb_enabled;

  // the status byte a status query sees: bit 6 is the master summary
  always_comb begin
    status_summary_byte = sb_low;
    status_summary_byte[SB_RQS] = master_summary_bit;
  end

  // last cycle's summary, for the rise detector
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      msb_q <= 1'b0;
    end else begin
      msb_q <= master_summary_bit;
    end
  end

  assign msb_rise = master_summary_bit & ~msb_q;
  assign flag_clear = do_serial_poll | ~master_summary_bit;

  // poll clears, but a fresh rise wins so a new request is never lost
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      request_service_flag_q <= 1'b0;
    end else if (msb_rise) begin
      request_service_flag_q <= 1'b1;
    end else if (flag_clear) begin
      request_service_flag_q <= 1'b0;
    end
  end

  // service request follows the flag, which only rises with bit 6
  assign service_request = request_service_flag_q;

  // a serial poll shows the flag in bit 6 instead of the summary
  always_comb begin
    poll_byte = sb_low;
    poll_byte[SB_RQS] = request_service_flag_q;
  end

  // reply data holds its value until the next query
  always_comb begin
    reply_d = reply_data_q;
    if (do_stb_query) begin
      reply_d = status_summary_byte;
    end else if (do_serial_poll) begin
      reply_d = poll_byte;
    end else if (do_esr_query) begin
      reply_d = standard_event_flags_q;
    end
  end

  assign any_query = do_stb_query | do_serial_poll | do_esr_query;

  // answer data registered one cycle after the strobe
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      reply_data_q <= '0;
    end else begin
      reply_data_q <= reply_d;
    end
  end

  // answer valid stands for exactly one cycle per query
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      reply_valid_q <= 1'b0;
    end else begin
      reply_valid_q <= any_query;
    end
  end

  // only a clear-status right after a terminator empties the output queue;
  // a plain clear-status leaves queued answers in place
  assign flush_output_queue = do_clear_status & at_terminator;
endmodule
`default_nettype wire

//--- hw/status_report_pkg.sv
package status_report_pkg;
  localparam int BYTE_W = 8;
  // status byte bit positions
  localparam int SB_EXT = 1;
  localparam int SB_ERR = 2;
  localparam int SB_MSG = 4;
  localparam int SB_STD = 5;
  localparam int SB_RQS = 6;
  // standard event bit positions
  localparam int SE_OPC = 0;
  localparam int SE_QYE = 2;
  localparam int SE_DDE = 3;
  localparam int SE_EXE = 4;
  localparam int SE_CME = 5;
  localparam int SE_PON = 7;
  localparam logic [7:0] MASK_RESET = 8'h00;
  localparam logic [7:0] EVENT_RESET = 8'h00;

  // one-cycle event pulses from the command engine
  typedef struct packed {
    logic operation_complete;
    logic query_error;
    logic device_specific_error;
    logic execution_error;
    logic command_syntax_error;
    logic power_on_event;
  } std_events_s;

  // one-cycle command strobes from the remote controller side
  typedef struct packed {
    logic stb_query;
    logic serial_poll;
    logic esr_query;
    logic clear_status;
    logic after_terminator;
    logic sre_write;
    logic ese_write;
    logic [7:0] wdata;
  } cmd_s;
endpackage

//--- verif/status_report_aggregator_checker.sv
`timescale 1ns/1ns
`default_nettype none
module status_report_aggregator_checker
  import status_report_pkg::*;
(
  input wire logic mclk,
  input wire logic rst_n,
  input wire cmd_s cmd,
  input wire logic error_queue_nonempty,
  input wire logic output_queue_nonempty,
  input wire logic flush_output_queue,
  input wire logic service_request,
  input wire logic [7:0] service_enable_q,
  input wire logic [7:0] event_enable_q,
  input wire logic [7:0] status_summary_byte,
  input wire logic [7:0] standard_event_flags_q
);
  wire [7:0] sb = status_summary_byte;
  wire [7:0] se = standard_event_flags_q;
  default clocking @(posedge mclk); endclocking
  default disable iff (!rst_n);
  sb_unused_a: assert property ((sb & 8'h89) == 8'h00) else $error("sb spare bit");
  err_bit_a: assert property (sb[2] == error_queue_nonempty) else $error("eav");
  msg_bit_a: assert property (sb[4] == output_queue_nonempty) else $error("mav");
  std_sum_a: assert property (sb[5] == |(se & event_enable_q)) else $error("esb");
  mss_calc_a: assert property (sb[6] == |(sb & service_enable_q & 8'hbf)) else $error("mss");
  flag_rise_a: assert property ($rose(sb[6]) |=> service_request) else $error("rqs");
  flush_out_a: assert property (flush_output_queue == (cmd.clear_status & cmd.after_terminator)) else $error("flush");
  se_spare_a: assert property ((se & 8'h42) == 8'h00) else $error("se spare bit");
endmodule
bind status_report_aggregator status_report_aggregator_checker chk (.mclk, .rst_n, .cmd, .error_queue_nonempty,
  .output_queue_nonempty, .flush_output_queue, .service_request, .service_enable_q, .event_enable_q,
  .status_summary_byte, .standard_event_flags_q);
`default_nettype wire

//--- verif/remote_ctrl_model.sv
`timescale 1ns/1ns
`default_nettype none
module remote_ctrl_model
  import status_report_pkg::*;
(
  input wire logic mclk,
  output var cmd_s cmd
);
  initial cmd = '0;
  // one strobe for one cycle; a byte field cannot leave 0..255
  task automatic send(input logic [6:0] k, input logic [7:0] v);
    @(negedge mclk) cmd = {k, v};
    @(negedge mclk) cmd = '0;
  endtask
endmodule
`default_nettype wire

//--- verif/status_report_aggregator_tb.sv
`timescale 1ns/1ns
`default_nettype none
module status_report_aggregator_tb;
  import status_report_pkg::*;
  logic mclk = 0, rst_n = 0, eq = 0, oq = 0, rv, fl, srq;
  std_events_s ev = '0;
  cmd_s cmd;
  logic [15:0] xe = '0, xn = '0;
  logic [7:0] rd, sen, een, sb, se, v;
  logic [7:0] exp_q[$];
  int mismatches = 0, compares = 0;
  int pos[6] = '{0, 2, 3, 4, 5, 7};
  initial forever #20 mclk = ~mclk;
  remote_ctrl_model ctl (.mclk, .cmd);
  status_report_aggregator dut (.mclk, .rst_n, .std_ev(ev), .cmd, .ext_event(xe), .ext_enable(xn),
    .error_queue_nonempty(eq), .output_queue_nonempty(oq), .flush_output_queue(fl), .service_request(srq),
    .reply_data_q(rd), .reply_valid_q(rv), .service_enable_q(sen), .event_enable_q(een),
    .status_summary_byte(sb), .standard_event_flags_q(se));
  task automatic chk(input logic [7:0] got, input logic [7:0] want);
    compares++;
    if (got !== want) begin
      mismatches++;
      $display("Error at %0t: got %h want %h", $time, got, want);
    end
  endtask
  task automatic ask(input logic [6:0] k, input logic [7:0] want);
    exp_q.push_back(want);
    ctl.send(k, 8'h00);
  endtask
  task automatic pulse(input std_events_s e);
    @(negedge mclk) ev = e;
    @(negedge mclk) ev = '0;
  endtask
  // replies stand one cycle, so mid-cycle sampling sees each exactly once
  always @(negedge mclk) if (rv === 1'b1) chk(rd, exp_q.size() ? exp_q.pop_front() : 8'hxx);
  // main sequence
  initial begin
    void'($urandom(86767));
    repeat (20) @(negedge mclk);
    rst_n = 1;
    ask(7'h10, 8'h00);
    chk(sen | een, 8'h00);
    for (int j = 0; j < 6; j++) begin
      pulse(6'h20 >> j);
      ask(7'h10, 8'h01 << pos[j]);
      ask(7'h10, 8'h00);
    end
    v = $urandom;
    ctl.send(7'h01, v);
    chk(een, v);
    xe = $urandom;
    xn = xe;
    @(negedge mclk) chk(sb & 8'h02, {6'h00, |xe, 1'b0});
    xn = '0;
    ctl.send(7'h01, 8'hff);
    ctl.send(7'h02, 8'h20);
    eq = 1;
    oq = 1;
    pulse(6'h04);
    @(negedge mclk) chk({7'h00, srq}, 8'h01);
    ask(7'h40, 8'h74);
    ask(7'h20, 8'h74);
    ask(7'h20, 8'h34);
    fork
      ctl.send(7'h08, 8'h00);
      @(negedge mclk) #1 chk({7'h00, fl}, 8'h00);
    join
    chk(sb, 8'h14);
    fork
      ctl.send(7'h0c, 8'h00);
      @(negedge mclk) #1 chk({7'h00, fl}, 8'h01);
    join
    for (int i = 0; i < 20 && exp_q.size() > 0; i++) @(negedge mclk);
    if (exp_q.size() > 0) mismatches++;
    pulse(6'h01);
    chk(se, 8'h80);
    @(negedge mclk) rst_n = 0;
    @(negedge mclk) rst_n = 1;
    chk(sen | een | se, 8'h00);
    conclude();
  end
  task automatic conclude;
    $display("compares %0d mismatches %0d", compares, mismatches);
    if (mismatches == 0 && compares > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
endmodule
`default_nettype wire
